/* File: hdl/pir_pkg.sv */
package pir_pkg;
   localparam logic [7:0] OFS_VENDOR  = 8'h00;
   localparam logic [7:0] OFS_DEVICE  = 8'h01;
   localparam logic [7:0] OFS_FLAGS   = 8'h02;
   localparam logic [7:0] OFS_MASK    = 8'h03;
   localparam int         BIT_FAULT   = 7;
   localparam int         BIT_SHDN    = 3;
   localparam int         BIT_HOT     = 0;
   localparam logic [7:0] FLAG_ACTIVE = 8'h89;
   localparam logic [7:0] FLAGS_RST   = 8'h00;
   localparam logic [7:0] MASK_RST    = 8'hFF;
   localparam logic [7:0] ZERO8       = 8'h00;
   // arbitrary neutral value, not any real maker's code
   localparam logic [7:0] VENDOR_CODE = 8'h5A;

   typedef struct packed {
      logic [1:0] silicon_revision_field;
      logic [1:0] variant;
      logic [3:0] part_id;
   } pir_devcode_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } pir_req_s;

   typedef struct packed {
      logic       any_pgood_fall;
      logic       ocp_step_down;
      logic       hot_cross;
      logic       crit_cross;
      logic       shutdown;
      logic       cause_recorded;
   } pir_evt_s;
endpackage

/* File: hdl/pir_flag.sv */
`timescale 1ns/1ns
module pir_flag
   import pir_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag_q
);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (set) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end
endmodule

/* File: hdl/pir_regs.sv */
`timescale 1ns/1ns
module pir_regs
   import pir_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire pir_req_s     req,
   input  wire pir_devcode_s otp_code,
   input  wire logic         otp_valid,
   input  wire pir_evt_s     evt,
   output logic [7:0]        rdata_q,
   output logic [7:0]        flags_q,
   output logic [7:0]        mask_q,
   output logic              irq_n
);
   pir_devcode_s dev_q;
   logic [7:0]   wr_flags;
   logic [2:0]   set_v;
   logic [2:0]   flag_v;
   logic [7:0]   rd_d;
   logic         flags_wr;
   logic         mask_wr;

   // one-time memory lands after reset, so it is caught clocked
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dev_q <= '0;
      end else if (otp_valid) begin
         dev_q <= otp_code;
      end
   end

   assign flags_wr = req.wr && (req.addr == OFS_FLAGS);
   assign mask_wr  = req.wr && (req.addr == OFS_MASK);
   // offsets 00h and 01h have no write decode, so such writes fall away
   assign wr_flags = flags_wr ? req.wdata : ZERO8;

   assign set_v[2] = evt.any_pgood_fall
                   | evt.ocp_step_down
                   | evt.hot_cross | evt.crit_cross;
   assign set_v[1] = evt.shutdown | evt.cause_recorded;
   assign set_v[0] = evt.hot_cross;

   pir_flag u_fault (
      .mclk   (mclk),
      .rst    (rst),
      .set    (set_v[2]),
      .clr    (wr_flags[BIT_FAULT]),
      .flag_q (flag_v[2])
   );

   pir_flag u_shdn (
      .mclk   (mclk),
      .rst    (rst),
      .set    (set_v[1]),
      .clr    (wr_flags[BIT_SHDN]),
      .flag_q (flag_v[1])
   );

   pir_flag u_hot (
      .mclk   (mclk),
      .rst    (rst),
      .set    (set_v[0]),
      .clr    (wr_flags[BIT_HOT]),
      .flag_q (flag_v[0])
   );

   always_comb begin
      flags_q = FLAGS_RST;
      flags_q[BIT_FAULT] = flag_v[2];
      flags_q[BIT_SHDN]  = flag_v[1];
      flags_q[BIT_HOT]   = flag_v[0];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mask_q <= MASK_RST;
      end else if (mask_wr) begin
         mask_q <= (req.wdata & FLAG_ACTIVE) | ~FLAG_ACTIVE;
      end
   end

   // vendor code has no write path at all
   always_comb begin
      case (req.addr)
         OFS_VENDOR: rd_d = VENDOR_CODE;
         OFS_DEVICE: rd_d = dev_q;
         OFS_FLAGS:  rd_d = flags_q;
         OFS_MASK:   rd_d = mask_q;
         default:    rd_d = ZERO8;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= ZERO8;
      end else begin
         rdata_q <= rd_d;
      end
   end

   assign irq_n = ~|(flags_q & ~mask_q);

   // set beats clear: a clear that meets an event is lost, host must clear again
   set_wins_a: assert property (
      @(posedge mclk) disable iff (rst)
      set_v[0] |=> flags_q[BIT_HOT])
      else $error("hot flag lost");

   fault_wins_a: assert property (
      @(posedge mclk) disable iff (rst)
      set_v[2] && wr_flags[BIT_FAULT] |=> flags_q[BIT_FAULT])
      else $error("fault set lost to clear");

   shdn_wins_a: assert property (
      @(posedge mclk) disable iff (rst)
      set_v[1] && wr_flags[BIT_SHDN] |=> flags_q[BIT_SHDN])
      else $error("shutdown set lost to clear");

   shdn_sticky_a: assert property (
      @(posedge mclk) disable iff (rst)
      flags_q[BIT_SHDN] && !wr_flags[BIT_SHDN] |=> flags_q[BIT_SHDN])
      else $error("shutdown flag dropped");

   fault_sticky_a: assert property (
      @(posedge mclk) disable iff (rst)
      flags_q[BIT_FAULT] && !wr_flags[BIT_FAULT] |=> flags_q[BIT_FAULT])
      else $error("fault flag dropped");

   hot_sticky_a: assert property (
      @(posedge mclk) disable iff (rst)
      flags_q[BIT_HOT] && !wr_flags[BIT_HOT] |=> flags_q[BIT_HOT])
      else $error("hot flag dropped");

   clear_one_a: assert property (
      @(posedge mclk) disable iff (rst)
      wr_flags[BIT_FAULT] && !set_v[2] |=> !flags_q[BIT_FAULT])
      else $error("fault flag not cleared");

   shdn_clear_a: assert property (
      @(posedge mclk) disable iff (rst)
      wr_flags[BIT_SHDN] && !set_v[1] |=> !flags_q[BIT_SHDN])
      else $error("shutdown flag not cleared");

   hot_clear_a: assert property (
      @(posedge mclk) disable iff (rst)
      wr_flags[BIT_HOT] && !set_v[0] |=> !flags_q[BIT_HOT])
      else $error("hot flag not cleared");

   zero_write_a: assert property (
      @(posedge mclk) disable iff (rst)
      flags_wr && (req.wdata & FLAG_ACTIVE) == ZERO8 |=> (flags_q & $past(flags_q)) == $past(flags_q))
      else $error("zero write dropped a flag");

   reserved_zero_a: assert property (
      @(posedge mclk) disable iff (rst)
      (flags_q & ~FLAG_ACTIVE) == ZERO8)
      else $error("reserved bit set");

   reserved_rd_a: assert property (
      @(posedge mclk) disable iff (rst)
      req.addr == OFS_FLAGS |=> (rdata_q & ~FLAG_ACTIVE) == ZERO8)
      else $error("reserved bit read back");

   flags_read_a: assert property (
      @(posedge mclk) disable iff (rst)
      req.addr == OFS_FLAGS |=> rdata_q == $past(flags_q))
      else $error("flag read wrong");

   vendor_read_a: assert property (
      @(posedge mclk) disable iff (rst)
      req.addr == OFS_VENDOR |=> rdata_q == VENDOR_CODE)
      else $error("vendor code wrong");

   dev_load_a: assert property (
      @(posedge mclk) disable iff (rst)
      otp_valid |=> dev_q == $past(otp_code))
      else $error("device code not loaded");

   dev_hold_a: assert property (
      @(posedge mclk) disable iff (rst)
      !otp_valid |=> $stable(dev_q))
      else $error("device code changed");

   dev_read_a: assert property (
      @(posedge mclk) disable iff (rst)
      req.addr == OFS_DEVICE |=> rdata_q == $past(dev_q))
      else $error("device code read wrong");

   cause_sets_a: assert property (
      @(posedge mclk) disable iff (rst)
      evt.cause_recorded |=> flags_q[BIT_SHDN])
      else $error("cause missed");

   shdn_sets_a: assert property (
      @(posedge mclk) disable iff (rst)
      evt.shutdown |=> flags_q[BIT_SHDN])
      else $error("shutdown missed");

   fault_sets_a: assert property (
      @(posedge mclk) disable iff (rst)
      evt.any_pgood_fall || evt.crit_cross |=> flags_q[BIT_FAULT])
      else $error("fault missed");

   ocp_sets_a: assert property (
      @(posedge mclk) disable iff (rst)
      evt.ocp_step_down |=> flags_q[BIT_FAULT])
      else $error("overcurrent missed");

   temp_fault_a: assert property (
      @(posedge mclk) disable iff (rst)
      evt.hot_cross || evt.crit_cross |=> flags_q[BIT_FAULT])
      else $error("temperature fault missed");

   hot_only_a: assert property (
      @(posedge mclk) disable iff (rst)
      !evt.hot_cross && !flags_q[BIT_HOT] |=> !flags_q[BIT_HOT])
      else $error("hot flag set without crossing");

   mask_fixed_a: assert property (
      @(posedge mclk) disable iff (rst)
      (mask_q | FLAG_ACTIVE) == MASK_RST)
      else $error("mask reserved");

   mask_write_a: assert property (
      @(posedge mclk) disable iff (rst)
      mask_wr |=> mask_q[BIT_FAULT] == $past(req.wdata[BIT_FAULT])
         && mask_q[BIT_SHDN] == $past(req.wdata[BIT_SHDN])
         && mask_q[BIT_HOT] == $past(req.wdata[BIT_HOT]))
      else $error("mask write lost");

   mask_hold_a: assert property (
      @(posedge mclk) disable iff (rst)
      !mask_wr |=> $stable(mask_q))
      else $error("mask changed without write");
endmodule

/* File: tb/pir_host.sv */
`timescale 1ns/1ns
module pir_host
   import pir_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] rdata,
   output pir_req_s        req
);
   initial req = '0;
   // write strobe held over one edge and left set until the next call, caller enters just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      req = '{a, v, 1'b1};
      @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      req = '{a, 8'h00, 1'b0};
      @(posedge mclk);
      #1 v = rdata;
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
   import pir_pkg::*;
   logic         mclk = 0, rst = 1, otp_valid = 0, irq_n;
   pir_devcode_s otp_code = '0;
   pir_evt_s     evt = '0;
   pir_req_s     req;
   logic [7:0]   rdata_q, flags_q, mask_q, d;
   logic [7:0]   exp [6] = '{8'h80, 8'h80, 8'h81, 8'h80, 8'h08, 8'h08};
   int           fails = 0, checks = 0, cyc = 0;
   always #5 mclk = ~mclk;
   pir_host HOST (.mclk(mclk), .rdata(rdata_q), .req(req));
   pir_regs DUT (.mclk(mclk), .rst(rst), .req(req), .otp_code(otp_code),
      .otp_valid(otp_valid), .evt(evt), .rdata_q(rdata_q), .flags_q(flags_q),
      .mask_q(mask_q), .irq_n(irq_n));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // whole run is under 100 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 500) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      #1 rst = 0;
      chk("flags", FLAGS_RST, flags_q);
      chk("mask", MASK_RST, mask_q);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      HOST.wr(OFS_VENDOR, 8'hFF);
      HOST.rd(OFS_VENDOR, d);
      chk("vendor", VENDOR_CODE, d);
      HOST.rd(OFS_DEVICE, d);
      chk("devcode", ZERO8, d);
      for (int v = 0; v < 4; v++) begin
         otp_code = '{2'b10, 2'(v), 4'h5};
         otp_valid = 1;
         HOST.wr(OFS_DEVICE, 8'h00);
         otp_valid = 0;
         HOST.wr(OFS_DEVICE, 8'hFF);
         HOST.rd(OFS_DEVICE, d);
         chk("devcode", {2'b10, 2'(v), 4'h5}, d);
      end
      HOST.rd(8'h40, d);
      chk("unmapped", 8'h00, d);
      $display("test ids done");
      for (int i = 0; i < 6; i++) begin
         evt = pir_evt_s'(6'h20 >> i);
         HOST.rd(OFS_FLAGS, d);
         evt = '0;
         HOST.wr(OFS_FLAGS, 8'h00);
         HOST.rd(OFS_FLAGS, d);
         chk("flag set", exp[i], d);
         HOST.wr(OFS_FLAGS, 8'hFF);
         HOST.rd(OFS_FLAGS, d);
         chk("flag clr", 8'h00, d);
      end
      $display("test events done");
      evt.shutdown = 1;
      HOST.wr(OFS_FLAGS, 8'h08);
      evt = '0;
      HOST.rd(OFS_FLAGS, d);
      chk("set wins", 8'h08, d);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      HOST.wr(OFS_MASK, 8'h00);
      chk("mask", 8'h76, mask_q);
      chk("irq_n", 8'h00, {7'h00, irq_n});
      HOST.rd(OFS_MASK, d);
      chk("mask rd", 8'h76, d);
      HOST.wr(OFS_FLAGS, 8'h08);
      HOST.rd(OFS_FLAGS, d);
      chk("shdn clr", 8'h00, d);
      chk("irq_n", 8'h01, {7'h00, irq_n});
      $display("test mask done");
      evt.hot_cross = 1;
      HOST.rd(OFS_FLAGS, d);
      evt = '0;
      chk("flags", 8'h81, flags_q);
      rst = 1;
      @(posedge mclk);
      #1 rst = 0;
      chk("flags", FLAGS_RST, flags_q);
      chk("mask", MASK_RST, mask_q);
      HOST.rd(OFS_FLAGS, d);
      chk("flags rd", FLAGS_RST, d);
      $display("test reset done");
      wrap_up();
   end
endmodule
